// ==== shared/bitop_exec_pkg.sv ====
// constants, layouts and carrier types of the bit, branch and call execution unit
`default_nettype none
package bitop_exec_pkg;
   // ==================================================================
   // opcodes
   localparam logic [7:0] OP_BIT_INV_XOR = 8'h6F;
   localparam logic [7:0] OP_COPY_TSET   = 8'hF2;
   localparam logic [7:0] OP_OR_SET      = 8'h0F;
   localparam logic [7:0] OP_CLEAR       = 8'h1F;
   localparam logic [7:0] OP_JUMP_BIT    = 8'hAF;
   localparam logic [7:0] OP_TSET_MEM    = 8'hF6;
   localparam logic [7:0] OP_CALL_ABS    = 8'hD2;
   localparam logic [7:0] OP_CALL_PAIR   = 8'h74;
   localparam logic [7:0] OP_CARRY_INV   = 8'h61;
   // ==================================================================
   // instruction lengths in bytes
   localparam logic [15:0] LEN_ONE   = 16'h0001;
   localparam logic [15:0] LEN_TWO   = 16'h0002;
   localparam logic [15:0] LEN_THREE = 16'h0003;
   localparam logic [15:0] SSP_STEP  = 16'h0002;
   // ==================================================================
   // execution times in clock cycles
   localparam logic [4:0] CYC_BIT_SHORT = 5'h06;
   localparam logic [4:0] CYC_BIT_LONG  = 5'h0E;
   localparam logic [4:0] CYC_JMP_NO    = 5'h0E;
   localparam logic [4:0] CYC_JMP_YES   = 5'h10;
   localparam logic [4:0] CYC_TSET_REG  = 5'h08;
   localparam logic [4:0] CYC_TSET_MEM  = 5'h14;
   localparam logic [4:0] CYC_CALL_ABS  = 5'h12;
   localparam logic [4:0] CYC_CALL_PAIR = 5'h10;
   localparam logic [4:0] CYC_CARRY     = 5'h06;
   localparam logic [4:0] CYC_ILLEGAL   = 5'h02;
   localparam logic [4:0] CNT_FIRST     = 5'h01;
   // ==================================================================
   // register map, byte addresses
   localparam int          AVS_AW     = 12;
   localparam logic [11:0] ADDR_EXEC  = 12'h000;
   localparam logic [11:0] ADDR_PC    = 12'h004;
   localparam logic [11:0] ADDR_SSP   = 12'h008;
   localparam logic [11:0] ADDR_FLAGS = 12'h00C;
   localparam logic [11:0] ADDR_STAT  = 12'h010;
   localparam logic [5:0]  WREG_PAGE  = 6'h01;
   localparam logic [1:0]  DMEM_PAGE  = 2'h1;
   // ==================================================================
   // reset values
   localparam logic [15:0] PC_RST  = 16'h0000;
   localparam logic [15:0] SSP_RST = 16'h0000;
   localparam int          SIGN_BIT = 7;
   // ==================================================================
   // carriers
   typedef struct packed {
      logic [2:0] idx;
      logic       flag;
      logic [3:0] wreg;
   } bit_operand_t;
   typedef struct packed {
      logic [7:0] b2;
      logic [7:0] b1;
      logic [7:0] opcode;
   } instr_t;
   typedef struct packed {
      logic v;
      logic s;
      logic z;
      logic c;
   } flags_t;
endpackage
`default_nettype wire

// ==== hw/bit_op_branch_call_exec.sv ====
// bit operation, bit-test branch, call and carry-invert execution unit
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`default_nettype none
// Function
// - 6F short form inverts working register bit
// - F2 long form copies bit or inverse
// - 0F long form ORs bit or inverse
// - 6F long form XORs bit or inverse
// - 1F short form clears register bit
// - 0F short form sets register bit
// - other bits unchanged, working registers only
// - source and destination may share register
// - AF flag set jumps when bit clear
// - AF flag clear jumps when bit one
// - bit branches take 14 or 16 cycles
// - test-and-set on register or memory byte
// - test-and-set updates zero, sign, overflow flags
// - call absolute or through register pair
// - call pushes return address, stack drops two
// - 61 inverts carry, other flags kept
module bit_op_branch_call_exec #(
   parameter int DMEM_AW = 8
) (
   input  wire logic                              i_ref_clk,
   input  wire logic                              i_srst,
   input  wire logic [bitop_exec_pkg::AVS_AW-1:0] i_avs_address,
   input  wire logic                              i_avs_read,
   input  wire logic                              i_avs_write,
   input  wire logic [31:0]                       i_avs_writedata,
   input  wire logic [3:0]                        i_avs_byteenable,
   output logic      [31:0]                       o_avs_readdata,
   output logic                                   o_avs_waitrequest
);
   import bitop_exec_pkg::*;

   // ==================================================================
   // parameter check
   if (DMEM_AW < 1 || DMEM_AW > 8) begin : g_bad_aw
      $error("DMEM_AW must lie between 1 and 8");
   end

   localparam int DMEM_DEPTH = 1 << DMEM_AW;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_BUSY,
      ST_ACK
   } bus_st_t;

   // ==================================================================
   // state
   bus_st_t      bus_q;
   logic [4:0]   cnt_q;
   logic         wait_q;
   logic [31:0]  rdata_q;
   logic [31:0]  rdata_d;
   instr_t       instr_q;
   logic [15:0]  pc_q;
   logic [15:0]  ssp_q;
   flags_t       flags_q;
   logic         illegal_q;
   logic         taken_q;
   logic [4:0]   last_cyc_q;
   logic [7:0]   wreg_q [16];
   logic [7:0]   dmem_q [DMEM_DEPTH];

   // ==================================================================
   // execution results
   logic         x_wreg_we;
   logic [3:0]   x_widx;
   logic [7:0]   x_wval;
   logic         x_mem_we;
   logic [15:0]  x_maddr;
   logic [7:0]   x_mval;
   logic         x_push;
   logic [15:0]  x_pc;
   logic [15:0]  x_ssp;
   logic [15:0]  x_ret;
   flags_t       x_flags;
   logic [4:0]   x_cycles;
   logic         x_illegal;
   logic         x_taken;

   // ==================================================================
   // bus decode
   logic         bus_rd;
   logic         bus_wr;
   logic         do_commit;
   logic         a_wreg;
   logic         a_dmem;
   logic [3:0]   a_widx;
   logic [7:0]   a_midx;
   logic [31:0]  wmask;
   logic [31:0]  wdata;

   assign bus_rd = (bus_q == ST_IDLE) && i_avs_read;
   assign bus_wr = (bus_q == ST_IDLE) && i_avs_write;
   assign a_wreg = (i_avs_address[11:6] == WREG_PAGE);
   assign a_widx = i_avs_address[5:2];
   assign a_midx = i_avs_address[9:2];
   assign a_dmem = (i_avs_address[11:10] == DMEM_PAGE) && (int'(a_midx) < DMEM_DEPTH);
   assign wmask  = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   assign wdata  = i_avs_writedata & wmask;
   assign do_commit = (bus_q == ST_BUSY) && (cnt_q == x_cycles - 5'h01);

   // ==================================================================
   // helpers
   function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] i,
                                          input logic b);
      logic [7:0] r;
      r    = v;
      r[i] = b;
      return r;
   endfunction

   function automatic logic [DMEM_AW-1:0] dm_idx(input logic [15:0] a);
      return a[DMEM_AW-1:0];
   endfunction

   // ==================================================================
   // decode and execute
   always_comb begin
      bit_operand_t op1;
      bit_operand_t op2;
      logic [7:0]   dval;
      logic         dbit;
      logic         sbit;
      logic [15:0]  pair;
      logic [7:0]   mval;
      logic         mbit;
      op1       = bit_operand_t'(instr_q.b1);
      op2       = bit_operand_t'(instr_q.b2);
      // operands are read before any write, so a shared register is safe
      // shared register
      dval      = wreg_q[op1.wreg];
      dbit      = dval[op1.idx];
      sbit      = wreg_q[op2.wreg][op2.idx];
      pair      = {wreg_q[{op1.wreg[3:1], 1'b0}], wreg_q[{op1.wreg[3:1], 1'b1}]};
      mval      = dmem_q[dm_idx(pair)];
      mbit      = mval[op1.idx];
      x_wreg_we = 1'b0;
      x_widx    = op1.wreg;
      x_wval    = dval;
      x_mem_we  = 1'b0;
      x_maddr   = pair;
      x_mval    = mval;
      x_push    = 1'b0;
      x_pc      = pc_q + LEN_TWO;
      x_ssp     = ssp_q;
      x_ret     = pc_q + LEN_TWO;
      x_flags   = flags_q;
      x_cycles  = CYC_BIT_SHORT;
      x_illegal = 1'b0;
      x_taken   = 1'b0;
      unique case (instr_q.opcode)
         OP_BIT_INV_XOR: begin
            x_wreg_we = 1'b1;
            if (!op1.flag) begin
               x_wval = put_bit(dval, op1.idx, ~dbit);
            end else begin
               x_wval   = put_bit(dval, op1.idx, dbit ^ (sbit ^ op2.flag));
               x_pc     = pc_q + LEN_THREE;
               x_cycles = CYC_BIT_LONG;
            end
         end
         OP_COPY_TSET: begin
            x_wreg_we = 1'b1;
            if (op1.flag) begin
               x_widx   = op2.wreg;
               x_wval   = put_bit(wreg_q[op2.wreg], op2.idx,
                                  wreg_q[op1.wreg][op1.idx] ^ op2.flag);
               x_pc     = pc_q + LEN_THREE;
               x_cycles = CYC_BIT_LONG;
            end else begin
               x_wval   = put_bit(dval, op1.idx, 1'b1);
               x_cycles = CYC_TSET_REG;
               x_flags.z = ~dbit;
               x_flags.s = (int'(op1.idx) == SIGN_BIT) && dbit;
               x_flags.v = 1'b0;
            end
         end
         OP_OR_SET: begin
            x_wreg_we = 1'b1;
            if (op1.flag) begin
               x_wval   = put_bit(dval, op1.idx, dbit | (sbit ^ op2.flag));
               x_pc     = pc_q + LEN_THREE;
               x_cycles = CYC_BIT_LONG;
            end else begin
               x_wval = put_bit(dval, op1.idx, 1'b1);
            end
         end
         OP_CLEAR: begin
            if (!op1.flag) begin
               x_wreg_we = 1'b1;
               x_wval    = put_bit(dval, op1.idx, 1'b0);
            end else begin
               x_illegal = 1'b1;
               x_pc      = pc_q;
               x_cycles  = CYC_ILLEGAL;
            end
         end
         OP_JUMP_BIT: begin
            x_taken = op1.flag ? ~dbit : dbit;
            x_pc    = pc_q + LEN_THREE;
            if (x_taken) begin
               x_pc = pc_q + LEN_THREE + {{8{instr_q.b2[7]}}, instr_q.b2};
            end
            x_cycles = x_taken ? CYC_JMP_YES : CYC_JMP_NO;
         end
         OP_TSET_MEM: begin
            x_mem_we  = 1'b1;
            x_mval    = put_bit(mval, op1.idx, 1'b1);
            x_cycles  = CYC_TSET_MEM;
            x_flags.z = ~mbit;
            x_flags.s = (int'(op1.idx) == SIGN_BIT) && mbit;
            x_flags.v = 1'b0;
         end
         OP_CALL_ABS: begin
            x_push   = 1'b1;
            x_ret    = pc_q + LEN_THREE;
            x_pc     = {instr_q.b1, instr_q.b2};
            x_ssp    = ssp_q - SSP_STEP;
            x_cycles = CYC_CALL_ABS;
         end
         OP_CALL_PAIR: begin
            x_push   = 1'b1;
            x_pc     = pair;
            x_ssp    = ssp_q - SSP_STEP;
            x_cycles = CYC_CALL_PAIR;
         end
         OP_CARRY_INV: begin
            x_flags.c = ~flags_q.c;
            x_pc      = pc_q + LEN_ONE;
            x_cycles  = CYC_CARRY;
         end
         default: begin
            // unknown opcodes leave all other state alone and only update the status word: illegal bit, taken bit, cycle count
            x_illegal = 1'b1;
            x_pc      = pc_q;
            x_cycles  = CYC_ILLEGAL;
         end
      endcase
   end

   // ==================================================================
   // read mux
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (a_wreg) begin
         rdata_d = {24'h00_0000, wreg_q[a_widx]};
      end else if (a_dmem) begin
         rdata_d = {24'h00_0000, dmem_q[a_midx[DMEM_AW-1:0]]};
      end else begin
         unique case (i_avs_address)
            ADDR_EXEC:  rdata_d = {8'h00, instr_q};
            ADDR_PC:    rdata_d = {16'h0000, pc_q};
            ADDR_SSP:   rdata_d = {16'h0000, ssp_q};
            ADDR_FLAGS: rdata_d = {28'h000_0000, flags_q};
            ADDR_STAT:  rdata_d = {19'h0_0000, last_cyc_q, 6'h00, taken_q, illegal_q};
            default:    rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // ==================================================================
   // bus handshake; waitrequest stays high for the whole execution time
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         bus_q   <= ST_IDLE;
         cnt_q   <= 5'h00;
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         unique case (bus_q)
            ST_IDLE: begin
               if (bus_wr && i_avs_address == ADDR_EXEC) begin
                  bus_q <= ST_BUSY;
                  cnt_q <= CNT_FIRST;
               end else if (bus_rd || bus_wr) begin
                  bus_q   <= ST_ACK;
                  wait_q  <= 1'b0;
                  rdata_q <= bus_rd ? rdata_d : 32'h0000_0000;
               end
            end
            ST_BUSY: begin
               if (do_commit) begin
                  bus_q  <= ST_ACK;
                  wait_q <= 1'b0;
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            ST_ACK: begin
               bus_q  <= ST_IDLE;
               wait_q <= 1'b1;
            end
         endcase
      end
   end

   assign o_avs_readdata    = rdata_q;
   assign o_avs_waitrequest = wait_q;

   // ==================================================================
   // instruction latch and status
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         instr_q    <= '0;
         illegal_q  <= 1'b0;
         taken_q    <= 1'b0;
         last_cyc_q <= 5'h00;
      end else if (bus_wr && i_avs_address == ADDR_EXEC) begin
         instr_q <= instr_t'(i_avs_writedata[23:0]);
      end else if (do_commit) begin
         illegal_q  <= x_illegal;
         taken_q    <= x_taken;
         last_cyc_q <= x_cycles;
      end
   end

   // ==================================================================
   // program counter, stack pointer, flags
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         pc_q    <= PC_RST;
         ssp_q   <= SSP_RST;
         flags_q <= '0;
      end else if (bus_wr && i_avs_address == ADDR_PC) begin
         pc_q <= (pc_q & ~wmask[15:0]) | wdata[15:0];
      end else if (bus_wr && i_avs_address == ADDR_SSP) begin
         ssp_q <= (ssp_q & ~wmask[15:0]) | wdata[15:0];
      end else if (bus_wr && i_avs_address == ADDR_FLAGS) begin
         flags_q <= (flags_q & ~wmask[3:0]) | wdata[3:0];
      end else if (do_commit) begin
         pc_q    <= x_pc;
         ssp_q   <= x_ssp;
         flags_q <= x_flags;
      end
   end

   // ==================================================================
   // working registers; a commit writes one byte and no other
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         for (int i = 0; i < 16; i++) begin
            wreg_q[i] <= 8'h00;
         end
      end else if (bus_wr && a_wreg && i_avs_byteenable[0]) begin
         wreg_q[a_widx] <= i_avs_writedata[7:0];
      end else if (do_commit && x_wreg_we) begin
         wreg_q[x_widx] <= x_wval;
      end
   end

   // ==================================================================
   // data memory; no reset, it holds data and pushed return addresses
   always_ff @(posedge i_ref_clk) begin
      if (bus_wr && a_dmem && i_avs_byteenable[0]) begin
         dmem_q[a_midx[DMEM_AW-1:0]] <= i_avs_writedata[7:0];
      end else if (do_commit && x_mem_we) begin
         dmem_q[dm_idx(x_maddr)] <= x_mval;
      end else if (do_commit && x_push) begin
         dmem_q[dm_idx(x_ssp)]            <= x_ret[15:8];
         dmem_q[dm_idx(x_ssp + LEN_ONE)]  <= x_ret[7:0];
      end
   end

endmodule
`default_nettype wire

// ==== verification/bit_op_branch_call_exec_props.sv ====
// concurrent checks on the register bus of the execution unit
`default_nettype none
module bit_op_branch_call_exec_props #(
   parameter int DMEM_AW = 8
) (
   input wire logic                              i_ref_clk,
   input wire logic                              i_srst,
   input wire logic [bitop_exec_pkg::AVS_AW-1:0] i_avs_address,
   input wire logic                              i_avs_read,
   input wire logic                              i_avs_write,
   input wire logic [31:0]                       i_avs_writedata,
   input wire logic [3:0]                        i_avs_byteenable,
   input wire logic [31:0]                       o_avs_readdata,
   input wire logic                              o_avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   import bitop_exec_pkg::*;
   logic        pend_q;
   logic        exec_q;
   logic [23:0] op_q;
   logic [5:0]  cnt_q;
   logic        take;
   logic        ans;
   logic [7:0]  op;
   logic        lf;
   assign take = (i_avs_read || i_avs_write) && !pend_q;
   assign ans  = pend_q && !o_avs_waitrequest && exec_q;
   assign op   = op_q[7:0];
   // long or test forms are told apart by the first operand flag
   assign lf   = op_q[12];
   // ==================================================================
   // request tracking
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         pend_q <= 1'b0;
      end else begin
         pend_q <= (i_avs_read || i_avs_write) && o_avs_waitrequest;
      end
   end
   // counts edges from the take edge, so it equals the answer latency
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         cnt_q  <= 6'h00;
         exec_q <= 1'b0;
         op_q   <= 24'h000000;
      end else if (take) begin
         cnt_q  <= 6'h01;
         exec_q <= i_avs_write && (i_avs_address == ADDR_EXEC);
         op_q   <= i_avs_writedata[23:0];
      end else if (pend_q) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end
   // ==================================================================
   // properties
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_srst);
   property p_cyc(hit, int n);
      ans && hit |-> cnt_q == n;
   endproperty
   AST_RESET_IDLE: assert property (disable iff (1'b0)
      i_srst |=> o_avs_waitrequest && o_avs_readdata == 32'h0)
      else $error("bus not idle after reset");
   AST_NO_SPURIOUS: assert property (!pend_q |-> o_avs_waitrequest)
      else $error("answer without request");
   AST_ONE_PULSE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("answer longer than one cycle");
   AST_PLAIN_ONE: assert property (pend_q && !o_avs_waitrequest && !exec_q |-> cnt_q == 1)
      else $error("plain access latency wrong");
   AST_INV_CYC: assert property (p_cyc(op == OP_BIT_INV_XOR && !lf, 6))
      else $error("invert cycles wrong");
   AST_LONG_CYC: assert property (p_cyc(lf && (op == OP_COPY_TSET ||
      op == OP_OR_SET || op == OP_BIT_INV_XOR), 14))
      else $error("long bit op cycles wrong");
   AST_CLEAR_CYC: assert property (p_cyc(op == OP_CLEAR && !lf, 6))
      else $error("clear cycles wrong");
   AST_SET_CYC: assert property (p_cyc(op == OP_OR_SET && !lf, 6))
      else $error("set cycles wrong");
   AST_JUMP_CYC: assert property (ans && op == OP_JUMP_BIT |->
      cnt_q == 14 || cnt_q == 16)
      else $error("bit branch cycles wrong");
   AST_TSET_CYC: assert property (p_cyc(op == OP_COPY_TSET && !lf, 8))
      else $error("register test-and-set cycles wrong");
   AST_TMEM_CYC: assert property (p_cyc(op == OP_TSET_MEM, 20))
      else $error("memory test-and-set cycles wrong");
   AST_CALL_ABS: assert property (p_cyc(op == OP_CALL_ABS, 18))
      else $error("absolute call cycles wrong");
   AST_CALL_PAIR: assert property (p_cyc(op == OP_CALL_PAIR, 16))
      else $error("pair call cycles wrong");
   AST_CARRY_CYC: assert property (p_cyc(op == OP_CARRY_INV, 6))
      else $error("carry invert cycles wrong");
   AST_ILL_CYC: assert property (p_cyc(op == OP_CLEAR && lf, 2))
      else $error("refused op cycles wrong");
   C_CALL: cover property (ans && op == OP_CALL_ABS);
   C_JUMP: cover property (ans && op == OP_JUMP_BIT && cnt_q == 16);
   C_CARRY: cover property (ans && op == OP_CARRY_INV);
   C_ILLEGAL: cover property (ans && cnt_q == 2);
endmodule
bind bit_op_branch_call_exec bit_op_branch_call_exec_props #(.DMEM_AW(DMEM_AW)) u_props (
   .i_ref_clk         (i_ref_clk),
   .i_srst            (i_srst),
   .i_avs_address     (i_avs_address),
   .i_avs_read        (i_avs_read),
   .i_avs_write       (i_avs_write),
   .i_avs_writedata   (i_avs_writedata),
   .i_avs_byteenable  (i_avs_byteenable),
   .o_avs_readdata    (o_avs_readdata),
   .o_avs_waitrequest (o_avs_waitrequest)
);
`default_nettype wire

// ==== verification/bit_op_branch_call_exec_tb_top.sv ====
// self-checking testbench of the execution unit over its register bus
`default_nettype none
module bit_op_branch_call_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bitop_exec_pkg::*;
   logic        ref_clk = 1'b0;
   logic        srst = 1'b1;
   logic [11:0] address = 12'h000;
   logic        rd_en = 1'b0;
   logic        wr_en = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        waitreq;
   logic [31:0] q;
   int          n;
   int          failures = 0;
   int          comparisons = 0;
   // small memory so call pushes wrap into a few checked bytes
   bit_op_branch_call_exec #(.DMEM_AW(4)) dut (
      .i_ref_clk         (ref_clk),
      .i_srst            (srst),
      .i_avs_address     (address),
      .i_avs_read        (rd_en),
      .i_avs_write       (wr_en),
      .i_avs_writedata   (wdata),
      .i_avs_byteenable  (4'hF),
      .o_avs_readdata    (rdata),
      .o_avs_waitrequest (waitreq)
   );
   always #4 ref_clk = ~ref_clk;
   // ==================================================================
   // tasks
   task automatic finish_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // holds the request until waitrequest is sampled low, n counts edges after take
   // no local limit: a hung answer is caught by the watchdog alone
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      n = -1;
      @(posedge ref_clk);
      rd_en <= ~wr;
      wr_en <= wr;
      address <= a;
      wdata <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (waitreq !== 1'b0);
      q = rdata;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask
   task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, exp, q);
   endtask
   task automatic ex(input logic [23:0] w, input logic [4:0] cyc);
      bus(1'b1, ADDR_EXEC, {8'h00, w});
      chk("cycles", {27'h0, cyc}, 32'(n));
   endtask
   function automatic logic [11:0] wa(input int r);
      return 12'h040 + 12'(r * 4);
   endfunction
   function automatic logic [11:0] dm(input int a);
      return 12'h400 + 12'(a * 4);
   endfunction
   // ==================================================================
   // tables: instruction, start values, expected register
   logic [23:0] sw[3] = '{24'h00A46F, 24'h00A41F, 24'h00A40F};
   logic [7:0]  si[3] = '{8'h20, 8'hFF, 8'h00};
   logic [7:0]  se[3] = '{8'h00, 8'hDF, 8'h20};
   logic [23:0] lw[7] = '{24'hB458F2, 24'hA458F2, 24'h48B40F, 24'h58B40F,
                          24'h48B46F, 24'h58B46F, 24'h04B46F};
   logic [7:0]  l4[7] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h20, 8'hDF, 8'h01};
   logic [7:0]  l8[7] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h00, 8'h00};
   logic [7:0]  le[7] = '{8'hDF, 8'h20, 8'h20, 8'h00, 8'h00, 8'hFF, 8'h21};
   logic [15:0] jw[5] = '{16'hD85A, 16'hD85A, 16'h284A, 16'h284A, 16'h805A};
   logic [7:0]  jr[5] = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h00};
   logic [7:0]  jp[5] = '{8'hA3, 8'hCB, 8'hF3, 8'hCB, 8'h4B};
   logic        jt[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
   logic [7:0]  tb1[4] = '{8'hA4, 8'hA4, 8'hE4, 8'hE4};
   logic [7:0]  tr[4] = '{8'h20, 8'h20, 8'hA0, 8'hA0};
   logic [3:0]  tf[4] = '{4'h3, 4'h1, 4'h3, 4'h5};
   initial begin
      repeat (20000) @(posedge ref_clk);
      chk("watchdog", 32'h0, 32'h1);
      finish_test();
   end
   // ==================================================================
   // main sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      rc("pc", ADDR_PC, 32'h0);
      rc("ssp", ADDR_SSP, 32'h0);
      rc("flags", ADDR_FLAGS, 32'h0);
      rc("unmapped", 12'h0FC, 32'h0);
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, wa(4), {24'h0, si[i]});
         ex(sw[i], CYC_BIT_SHORT);
         rc("wreg4", wa(4), {24'h0, se[i]});
      end
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, wa(4), {24'h0, l4[i]});
         bus(1'b1, wa(8), {24'h0, l8[i]});
         ex(lw[i], CYC_BIT_LONG);
         rc("wreg4", wa(4), {24'h0, le[i]});
      end
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, wa(10), {24'h0, jr[i]});
         bus(1'b1, ADDR_PC, 32'h00C8);
         ex({jw[i], OP_JUMP_BIT}, jt[i] ? CYC_JMP_YES : CYC_JMP_NO);
         rc("pc", ADDR_PC, {24'h0, jp[i]});
         rc("status", ADDR_STAT, {19'h0, jt[i] ? CYC_JMP_YES : CYC_JMP_NO, 6'h0, jt[i],
            1'b0});
      end
      bus(1'b1, ADDR_FLAGS, 32'hF);
      bus(1'b1, wa(4), 32'h0);
      for (int i = 0; i < 4; i++) begin
         ex({8'h00, tb1[i], OP_COPY_TSET}, CYC_TSET_REG);
         rc("wreg4", wa(4), {24'h0, tr[i]});
         rc("flags", ADDR_FLAGS, {28'h0, tf[i]});
      end
      bus(1'b1, ADDR_FLAGS, 32'h0);
      bus(1'b1, wa(2), 32'h0);
      bus(1'b1, wa(3), 32'h5);
      bus(1'b1, dm(5), 32'h0);
      ex(24'h0062F6, CYC_TSET_MEM);
      rc("mem5", dm(5), 32'h08);
      rc("flags", ADDR_FLAGS, 32'h2);
      bus(1'b1, ADDR_PC, 32'h1A47);
      bus(1'b1, ADDR_SSP, 32'h3002);
      ex(24'h2135D2, CYC_CALL_ABS);
      rc("pc", ADDR_PC, 32'h3521);
      rc("ssp", ADDR_SSP, 32'h3000);
      rc("push hi", dm(0), 32'h1A);
      rc("push lo", dm(1), 32'h4A);
      bus(1'b1, wa(2), 32'h12);
      bus(1'b1, wa(3), 32'h34);
      ex(24'h000274, CYC_CALL_PAIR);
      rc("pc", ADDR_PC, 32'h1234);
      rc("ssp", ADDR_SSP, 32'h2FFE);
      rc("push hi", dm(14), 32'h35);
      rc("push lo", dm(15), 32'h23);
      ex(24'h000000, CYC_ILLEGAL);
      rc("status", ADDR_STAT, 32'h0201);
      rc("pc", ADDR_PC, 32'h1234);
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, ADDR_FLAGS, i ? 32'h0 : 32'hF);
         bus(1'b1, ADDR_PC, 32'h0010);
         ex({16'h0, OP_CARRY_INV}, CYC_CARRY);
         rc("flags", ADDR_FLAGS, i ? 32'h1 : 32'hE);
         rc("pc", ADDR_PC, 32'h0011);
      end
      bus(1'b1, wa(4), 32'h0);
      ex(24'h58B41F, CYC_ILLEGAL);
      rc("status", ADDR_STAT, 32'h0201);
      rc("wreg4", wa(4), 32'h0);
      @(posedge ref_clk);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      rc("pc", ADDR_PC, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
